// file: src/esp_echo_stop_manager.v
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "esp_defines.vh"

module esp_echo_stop_manager (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // receive cycle control
  input  wire        rxCycleStart,
  // comparator pins
  input  wire        thresholdComp,
  input  wire        zeroCrossComp,
  // stop output
  output reg         stopPulse,
  // analog front end settings
  output reg  [2:0]  ampGainStepCode,
  output reg         ampBypass,
  output reg         ampPowerDown,
  output reg  [2:0]  echoThresholdCode,
  output reg         midrailBufferEnable,
  output reg         rtdTypeSelect,
  output reg         offsetCancelActive,
  // divided clocks
  output wire        burstClk,
  output wire        tempClk
);

  // ==========================================================
  // event manager states
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_CANCEL = 2'b01;
  localparam [1:0] ST_LISTEN = 2'b10;
  localparam [1:0] ST_DONE   = 2'b11;

  // ==========================================================
  // declarations
  reg  [`ESP_CTRL_WIDTH-1:0] ctrl_reg;
  reg  [`ESP_CFG_WIDTH-1:0]  cfg_reg;
  reg                        ack_reg;
  reg  [1:0]                 state_reg;
  reg  [1:0]                 state_next;
  reg  [2:0]                 issued_reg;
  reg  [2:0]                 issued_next;
  reg                        qualified_reg;
  reg                        qualified_next;
  reg  [9:0]                 cancelCount_reg;
  reg  [9:0]                 cancelCount_next;
  reg                        stop_next;
  reg  [1:0]                 thrSync_reg;
  reg  [1:0]                 zcSync_reg;
  reg                        zcDelay_reg;
  reg  [31:0]                readValue;
  wire                       zcRise;
  wire                       limitReached;
  wire [2:0]                 stopLimit;
  wire [1:0]                 cancelCode;
  wire [31:0]                laneMask;
  wire                       access;
  wire                       wrStrobe;
  wire                       rdStrobe;
  wire [2:0]                 issuedPlusOne;

  // ==========================================================
  // helper functions
  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function [9:0] cancel_cycles;
    input [1:0] code;
    integer     full;
    reg   [9:0] base;
    begin
      full          = `ESP_OCD_BASE_CYCLES;
      base          = full[9:0];
      cancel_cycles = base << code;
    end
  endfunction

  function [`ESP_CTRL_WIDTH-1:0] merge_ctrl;
    input [`ESP_CTRL_WIDTH-1:0] old;
    input [31:0]                data;
    input [31:0]                mask;
    begin
      merge_ctrl = (old & ~mask[`ESP_CTRL_WIDTH-1:0])
                 | (data[`ESP_CTRL_WIDTH-1:0] & mask[`ESP_CTRL_WIDTH-1:0]);
    end
  endfunction

  function [`ESP_CFG_WIDTH-1:0] merge_cfg;
    input [`ESP_CFG_WIDTH-1:0] old;
    input [31:0]               data;
    input [31:0]               mask;
    begin
      merge_cfg = (old & ~mask[`ESP_CFG_WIDTH-1:0])
                | (data[`ESP_CFG_WIDTH-1:0] & mask[`ESP_CFG_WIDTH-1:0]);
    end
  endfunction

  function at_limit;
    input [2:0] count;
    input [2:0] limit;
    begin
      at_limit = (count >= limit);
    end
  endfunction

  function [1:0] listen_or_done;
    input [2:0] limit;
    begin
      listen_or_done = (limit == 3'h0) ? ST_DONE : ST_LISTEN;
    end
  endfunction

  function [31:0] status_word;
    input [2:0] issued;
    input       qualified;
    input       cancelling;
    input       atLimit;
    input       thrLevel;
    input       zcLevel;
    input [1:0] state;
    begin
      status_word      = 32'h0000_0000;
      status_word[2:0] = issued;
      status_word[3]   = qualified;
      status_word[4]   = cancelling;
      status_word[5]   = atLimit;
      status_word[6]   = thrLevel;
      status_word[7]   = zcLevel;
      status_word[9:8] = state;
    end
  endfunction

  // ==========================================================
  // bus slave: one wait cycle, answer on second edge
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_reg;
  assign laneMask        = lane_mask(avs_byteenable);
  // requests act only in their wait cycle
  assign wrStrobe        = avs_write & ~ack_reg;
  assign rdStrobe        = avs_read & ~ack_reg;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end

  always @* begin
    readValue = 32'h0000_0000;
    if (avs_address == `ESP_ADDR_CTRL) begin
      readValue[`ESP_CTRL_WIDTH-1:0] = ctrl_reg;
    end else if (avs_address == `ESP_ADDR_EVENT_CFG) begin
      readValue[`ESP_CFG_WIDTH-1:0] = cfg_reg;
    end else if (avs_address == `ESP_ADDR_STATUS) begin
      readValue = status_word(issued_reg, qualified_reg, offsetCancelActive, limitReached,
                              thrSync_reg[1], zcSync_reg[1], state_reg);
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rdStrobe) begin
      avs_readdata <= readValue;
    end
  end

  // ==========================================================
  // configuration registers
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `ESP_CTRL_RESET;
      cfg_reg  <= `ESP_CFG_RESET;
    end else if (wrStrobe) begin
      // status and unmapped writes fall through
      if (avs_address == `ESP_ADDR_CTRL) begin
        ctrl_reg <= merge_ctrl(ctrl_reg, avs_writedata, laneMask);
      end else if (avs_address == `ESP_ADDR_EVENT_CFG) begin
        cfg_reg <= merge_cfg(cfg_reg, avs_writedata, laneMask);
      end
    end
  end

  // ==========================================================
  // front end setting outputs
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ampGainStepCode     <= 3'h0;
      ampBypass           <= 1'b0;
      ampPowerDown        <= 1'b0;
      echoThresholdCode   <= 3'h0;
      midrailBufferEnable <= 1'b1;
      rtdTypeSelect       <= 1'b0;
    end else begin
      // gain in dB is three times the code
      ampGainStepCode     <= ctrl_reg[`ESP_CTRL_GAIN_MSB:`ESP_CTRL_GAIN_LSB];
      ampBypass           <= ctrl_reg[`ESP_CTRL_BYPASS];
      ampPowerDown        <= ctrl_reg[`ESP_CTRL_BYPASS];
      echoThresholdCode   <= ctrl_reg[`ESP_CTRL_THLD_MSB:`ESP_CTRL_THLD_LSB];
      midrailBufferEnable <= ~ctrl_reg[`ESP_CTRL_MIDRAIL];
      rtdTypeSelect       <= ctrl_reg[`ESP_CTRL_RTD];
    end
  end

  // ==========================================================
  // comparator synchronisers
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      thrSync_reg <= 2'b00;
      zcSync_reg  <= 2'b00;
      zcDelay_reg <= 1'b0;
    end else begin
      thrSync_reg <= {thrSync_reg[0], thresholdComp};
      // hysteresis is in the comparator; only its rising edge counts
      zcSync_reg  <= {zcSync_reg[0], zeroCrossComp};
      zcDelay_reg <= zcSync_reg[1];
    end
  end

  assign zcRise       = zcSync_reg[1] & ~zcDelay_reg;
  assign stopLimit    = cfg_reg[`ESP_CFG_LIMIT_MSB:`ESP_CFG_LIMIT_LSB];
  assign cancelCode   = cfg_reg[`ESP_CFG_OCD_MSB:`ESP_CFG_OCD_LSB];
  assign limitReached = at_limit(issued_reg, stopLimit);
  assign issuedPlusOne = issued_reg + 3'h1;

  // ==========================================================
  // event manager
  always @* begin
    state_next       = state_reg;
    issued_next      = issued_reg;
    qualified_next   = qualified_reg;
    cancelCount_next = cancelCount_reg;
    stop_next        = 1'b0;
    if (rxCycleStart) begin
      // restart wipes count and qualification
      state_next       = ST_CANCEL;
      issued_next      = 3'h0;
      qualified_next   = 1'b0;
      cancelCount_next = cancel_cycles(cancelCode);
    end else begin
      case (state_reg)
        ST_IDLE: begin
          qualified_next = 1'b0;
        end
        ST_CANCEL: begin
          // zero-crosses are dropped here
          qualified_next = 1'b0;
          if (cancelCount_reg <= 10'h001) begin
            cancelCount_next = 10'h000;
            // a zero limit skips listening
            state_next       = listen_or_done(stopLimit);
          end else begin
            cancelCount_next = cancelCount_reg - 10'h001;
          end
        end
        ST_LISTEN: begin
          if (zcRise && qualified_reg && !limitReached) begin
            stop_next   = 1'b1;
            issued_next = issuedPlusOne;
            // multiple echo mode needs a new crossing per pulse
            if (ctrl_reg[`ESP_CTRL_RXMODE]) begin
              qualified_next = 1'b0;
            end
            if (at_limit(issuedPlusOne, stopLimit)) begin
              state_next = ST_DONE;
            end
          end else if (thrSync_reg[1]) begin
            qualified_next = 1'b1;
          end
        end
        ST_DONE: begin
          // further zero-crosses ignored until restart
          qualified_next = 1'b0;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg          <= ST_IDLE;
      issued_reg         <= 3'h0;
      qualified_reg      <= 1'b0;
      cancelCount_reg    <= 10'h000;
      stopPulse          <= 1'b0;
      offsetCancelActive <= 1'b0;
    end else begin
      state_reg          <= state_next;
      issued_reg         <= issued_next;
      qualified_reg      <= qualified_next;
      cancelCount_reg    <= cancelCount_next;
      stopPulse          <= stop_next;
      offsetCancelActive <= (state_next == ST_CANCEL);
    end
  end

  // ==========================================================
  // burst and temperature clocks
  esp_clock_divider u_divider (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .burstDivCode (cfg_reg[`ESP_CFG_DIV_MSB:`ESP_CFG_DIV_LSB]),
    .tempClkSel   (ctrl_reg[`ESP_CTRL_TCLK]),
    .burstClk     (burstClk),
    .tempClk      (tempClk)
  );

endmodule // esp_echo_stop_manager

// file: src/esp_defines.vh
`ifndef ESP_DEFINES_VH
`define ESP_DEFINES_VH

// ==========================================================
// register byte offsets
`define ESP_ADDR_CTRL        4'h0
`define ESP_ADDR_EVENT_CFG   4'h4
`define ESP_ADDR_STATUS      4'h8

// ==========================================================
// control register fields
`define ESP_CTRL_GAIN_LSB    0
`define ESP_CTRL_GAIN_MSB    2
`define ESP_CTRL_BYPASS      3
`define ESP_CTRL_THLD_LSB    4
`define ESP_CTRL_THLD_MSB    6
`define ESP_CTRL_MIDRAIL     7
`define ESP_CTRL_RTD         8
`define ESP_CTRL_TCLK        9
`define ESP_CTRL_RXMODE      10
`define ESP_CTRL_WIDTH       11
`define ESP_CTRL_RESET       11'h000

// ==========================================================
// event configuration fields
`define ESP_CFG_LIMIT_LSB    0
`define ESP_CFG_LIMIT_MSB    2
`define ESP_CFG_OCD_LSB      4
`define ESP_CFG_OCD_MSB      5
`define ESP_CFG_DIV_LSB      8
`define ESP_CFG_DIV_MSB      10
`define ESP_CFG_WIDTH        11
`define ESP_CFG_RESET        11'h001

// ==========================================================
// timing
`define ESP_CLK_PERIOD_NS    20
`define ESP_OCD_BASE_NS      1280
`define ESP_OCD_BASE_CYCLES  (`ESP_OCD_BASE_NS / `ESP_CLK_PERIOD_NS)
`define ESP_TEMP_FIXED_DIV   8

`endif

// file: src/esp_clock_divider.v
`timescale 1ns/1ps
`include "esp_defines.vh"

module esp_clock_divider (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  // settings
  input  wire [2:0] burstDivCode,
  input  wire       tempClkSel,
  // divided clocks
  output reg        burstClk,
  output reg        tempClk
);

  reg [7:0] divCount_reg;
  wire      burstNext;
  wire      fixedNext;

  // ==========================================================
  // free running prescaler
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount_reg <= 8'h00;
    end else begin
      divCount_reg <= divCount_reg + 8'h01;
    end
  end

  // bit n toggles with period 2^(n+1) input clocks
  assign burstNext = divCount_reg[burstDivCode];
  assign fixedNext = divCount_reg[$clog2(`ESP_TEMP_FIXED_DIV) - 1];

  // ==========================================================
  // registered outputs
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      burstClk <= 1'b0;
      tempClk  <= 1'b0;
    end else begin
      burstClk <= burstNext;
      tempClk  <= tempClkSel ? burstNext : fixedNext;
    end
  end

endmodule // esp_clock_divider

// file: verification/esp_echo_props.sv
`timescale 1ns/1ps
module esp_echo_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // event path
  input wire logic rxCycleStart,
  input wire logic stopPulse,
  input wire logic offsetCancelActive,
  // amplifier settings
  input wire logic ampBypass,
  input wire logic ampPowerDown
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // sequences
  sequence cancelRun;
    offsetCancelActive [*8];
  endsequence
  sequence quietStop;
    !stopPulse [*2];
  endsequence
  // ==========================================
  // properties
  a_cancel_start: assert property (rxCycleStart |=> cancelRun)
    else $error("cancel interval did not start");
  a_cancel_quiet: assert property (offsetCancelActive |-> !stopPulse)
    else $error("stop pulse during cancel");
  a_cancel_tail: assert property ($fell(offsetCancelActive) |-> quietStop)
    else $error("stop pulse right after cancel");
  a_start_quiet: assert property (rxCycleStart |=> quietStop)
    else $error("stop pulse right after start");
  a_stop_single: assert property (stopPulse |=> !stopPulse)
    else $error("stop pulse longer than one cycle");
  a_bypass_pd: assert property (ampBypass == ampPowerDown)
    else $error("bypass and power down differ");
  a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("no wait cycle on new request");
  a_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
endmodule // esp_echo_props

bind esp_echo_stop_manager esp_echo_props u_props (
  .core_clk(core_clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .rxCycleStart(rxCycleStart), .stopPulse(stopPulse),
  .offsetCancelActive(offsetCancelActive), .ampBypass(ampBypass), .ampPowerDown(ampPowerDown)
);

// file: verification/esp_stopwatch_model.sv
`timescale 1ns/1ps
module esp_stopwatch_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // device side
  input  wire logic stopPulse,
  input  wire logic midrailBufferEnable,
  // observed
  output int        stopCount,
  output logic      midrailRefExt
);
  // external reference supplied while buffer is off
  assign midrailRefExt = !midrailBufferEnable;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) stopCount <= 0;
    else if (stopPulse) stopCount <= stopCount + 1;
  end
endmodule // esp_stopwatch_model

// file: verification/echo_stop_pulse_manager_test.sv
`timescale 1ns/1ps
module echo_stop_pulse_manager_test;
  logic        core_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, rd, v;
  logic        rxCycleStart = 0, thresholdComp = 0, zeroCrossComp = 0;
  wire  [31:0] avs_readdata;
  wire  [2:0]  ampGainStepCode, echoThresholdCode;
  wire         avs_waitrequest, stopPulse, ampBypass, ampPowerDown;
  wire         midrailBufferEnable, rtdTypeSelect, offsetCancelActive, burstClk, tempClk;
  wire         midrailRefExt;
  int          stopCount, n_errors = 0, compares = 0, i, p;
  esp_echo_stop_manager DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxCycleStart(rxCycleStart),
    .thresholdComp(thresholdComp), .zeroCrossComp(zeroCrossComp), .stopPulse(stopPulse),
    .ampGainStepCode(ampGainStepCode), .ampBypass(ampBypass), .ampPowerDown(ampPowerDown),
    .echoThresholdCode(echoThresholdCode), .midrailBufferEnable(midrailBufferEnable),
    .rtdTypeSelect(rtdTypeSelect), .offsetCancelActive(offsetCancelActive),
    .burstClk(burstClk), .tempClk(tempClk));
  esp_stopwatch_model u_watch (.core_clk(core_clk), .rst_b(rst_b), .stopPulse(stopPulse),
    .midrailBufferEnable(midrailBufferEnable), .stopCount(stopCount),
    .midrailRefExt(midrailRefExt));
  initial forever #10 core_clk = ~core_clk;
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic period(input logic brst, output int pr);
    logic prv = 1, cur;
    int st = -1;
    pr = 0;
    for (int k = 0; k < 700; k++) begin
      @(posedge core_clk);
      cur = brst ? burstClk : tempClk;
      if (cur === 1'b1 && !prv) begin
        if (st >= 0) begin
          pr = k - st;
          break;
        end
        st = k;
      end
      prv = cur;
    end
  endtask
  task automatic echo(input logic md, input logic [2:0] lim, input logic thr, input int nzc);
    logic [1:0] ocd = $urandom % 4;
    int c0, len = 0, ex, dn;
    bus(1, 4'h0, {21'h0, md, 10'h0});
    bus(1, 4'h4, {26'h0, ocd, 1'b0, lim});
    c0 = stopCount;
    @(posedge core_clk) rxCycleStart <= 1;
    @(posedge core_clk) rxCycleStart <= 0;
    while (len < 600) begin
      @(posedge core_clk);
      if (offsetCancelActive !== 1'b1) break;
      len++;
      zeroCrossComp <= (len > 3 && len < 8);
    end
    chk("cancel length", len, 64 << ocd);
    if (thr) thresholdComp <= 1;
    repeat (5) @(posedge core_clk);
    thresholdComp <= 0;
    repeat (5) @(posedge core_clk);
    for (int k = 0; k < nzc; k++) begin
      zeroCrossComp <= 1;
      repeat (4) @(posedge core_clk);
      zeroCrossComp <= 0;
      repeat (8) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
    ex = !thr ? 0 : md ? (lim > 0) : (nzc < lim ? nzc : lim);
    chk("stop count", stopCount - c0, ex);
    dn = (ex >= lim);
    bus(0, 4'h8, 0);
    chk("status", rd, ex + 8 * (thr && !md && !dn) + 32 * dn + 256 * (2 + dn));
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    #1_000_000;
    n_errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(2373));
    repeat (6) @(posedge core_clk);
    rst_b <= 1;
    chk("buffer on", midrailBufferEnable, 1);
    bus(0, 4'h0, 0);
    chk("ctrl reset", rd, 0);
    bus(0, 4'h4, 0);
    chk("cfg reset", rd, 1);
    bus(0, 4'hC, 0);
    chk("unmapped", rd, 0);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = ($urandom & 32'h188) | i | (i << 4);
      bus(1, 4'h0, v);
      bus(0, 4'h0, 0);
      chk("ctrl", rd, v);
      chk("gain", ampGainStepCode, i);
      chk("threshold", echoThresholdCode, i);
      chk("bypass", ampBypass, v[3]);
      chk("power down", ampPowerDown, v[3]);
      chk("buffer", midrailBufferEnable, !v[7]);
      chk("ext reference", midrailRefExt, v[7]);
      chk("rtd", rtdTypeSelect, v[8]);
    end
    avs_byteenable <= 4'h1;
    bus(1, 4'h0, 32'h7FF);
    avs_byteenable <= 4'hF;
    bus(0, 4'h0, 0);
    chk("lane write", rd, (v & 32'h700) | 32'hFF);
    $display("test settings done");
    bus(1, 4'h0, 0);
    period(0, p);
    period(0, p);
    chk("temp fixed", p, 8);
    for (i = 0; i < 8; i++) begin
      bus(1, 4'h4, {21'h0, i[2:0], 8'h01});
      bus(1, 4'h0, 32'h200);
      period(0, p);
      period(0, p);
      chk("temp burst", p, 2 << i);
      period(1, p);
      chk("burst", p, 2 << i);
    end
    // last setting keeps the temperature clock at or below 1 MHz
    chk("temp rate", p >= 50, 1);
    $display("test clocks done");
    bus(1, 4'h4, 32'h1);
    echo(0, 2, 1, 3);
    echo(1, 3, 1, 3);
    echo(0, 1, 0, 2);
    echo(0, 0, 1, 2);
    echo(0, 3, 1, 3);
    echo(0, 7, 1, 4);
    $display("test echo done");
    wrap_up;
  end
endmodule // echo_stop_pulse_manager_test
